/* hdl/i2c_master_collision_brg.sv */
// Repeated start and stop sequencing with collision checks, a byte
// shifter, and the baud generator, behind an AXI4-Lite slave.
// Assumes open-drain SDA and SCL resolved outside; oe high pulls low.
`include "i2c_brg_consts.svh"
module i2c_master_collision_brg
   import i2c_brg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe
);
   lines_t     meta_ff;
   lines_t     sync_ff;
   lines_t     prev_ff;
   state_t     state_ff;
   logic [7:0] reload_ff;
   logic [7:0] buffer_ff;
   logic [7:0] ctrl_ff;
   logic [1:0] flags_ff;
   logic       stopSeen_ff;
   logic       startSeen_ff;
   logic       collPend_ff;
   logic [7:0] awAddr_ff;
   logic       awGot_ff;
   logic [7:0] wData_ff;
   logic       wLane_ff;
   logic       wGot_ff;
   logic       txReq_ff;
   logic [7:0] brgCnt_ff;
   logic       brgPre_ff;
   logic       brgRun_ff;
   logic       brgLoad_ff;
   logic       collEv_ff;
   logic       doneEv_ff;
   logic       txDone_ff;
   logic [8:0] txSh_ff;
   logic [3:0] bitCnt_ff;
   logic       wrEn;
   logic       brgExp;
   logic       idleFree;
   logic       stopBus;
   logic       startBus;
   logic       wrMapped;
   logic       rdMapped;
   logic [7:0] rdByte;

   assign wrEn = awGot_ff & wGot_ff & ~bvalid;
   assign brgExp = brgRun_ff & brgPre_ff & (brgCnt_ff == 8'h00);
   assign idleFree = (state_ff == ST_IDLE) & ~collEv_ff & ~doneEv_ff;
   assign stopBus = sync_ff.scl & prev_ff.scl & ~prev_ff.sda & sync_ff.sda;
   assign startBus = sync_ff.scl & prev_ff.scl & prev_ff.sda & ~sync_ff.sda;
   assign wrMapped = (awAddr_ff == `OFF_RELOAD) |
                     (awAddr_ff == `OFF_BUFFER) |
                     (awAddr_ff == `OFF_CTRL2) |
                     (awAddr_ff == `OFF_FLAGS) |
                     (awAddr_ff == `OFF_STATUS);

   // Both bus lines are brought into the clock domain before any check.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_ff <= '{scl: 1'b1, sda: 1'b1};
         sync_ff <= '{scl: 1'b1, sda: 1'b1};
         prev_ff <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         meta_ff <= '{scl: sclIn, sda: sdaIn};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // Write address and data channels are taken in either order.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         awGot_ff <= 1'b0;
         wGot_ff  <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff <= 8'h00;
         wLane_ff <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= `RESP_OKAY;
      end else begin
         if (awready && awvalid) begin
            awAddr_ff <= awaddr;
            awGot_ff  <= 1'b1;
            awready   <= 1'b0;
         end
         if (wready && wvalid) begin
            wData_ff <= wdata[7:0];
            wLane_ff <= wstrb[0];
            wGot_ff  <= 1'b1;
            wready   <= 1'b0;
         end
         if (wrEn) begin
            bvalid <= 1'b1;
            bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid   <= 1'b0;
            awGot_ff <= 1'b0;
            wGot_ff  <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
         end
      end
   end

   always_comb begin
      rdByte = 8'h00;
      rdMapped = 1'b1;
      if (araddr == `OFF_RELOAD) begin
         rdByte = reload_ff;
      end else if (araddr == `OFF_BUFFER) begin
         rdByte = buffer_ff;
      end else if (araddr == `OFF_CTRL2) begin
         rdByte = ctrl_ff;
      end else if (araddr == `OFF_FLAGS) begin
         rdByte = {6'h00, flags_ff};
      end else if (araddr == `OFF_STATUS) begin
         rdByte = {3'h0, stopSeen_ff, startSeen_ff,
                   ~(state_ff == ST_IDLE), 2'h0};
      end else begin
         rdMapped = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         if (arready && arvalid) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rdByte};
            rresp   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Software registers. Sequence bits clear when the sequence ends.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reload_ff <= `RST_BYTE;
         buffer_ff <= `RST_BYTE;
         ctrl_ff   <= `RST_BYTE;
         txReq_ff  <= 1'b0;
      end else begin
         txReq_ff <= 1'b0;
         if (wrEn && wLane_ff && awAddr_ff == `OFF_RELOAD) begin
            reload_ff <= wData_ff;
         end
         if (wrEn && wLane_ff && awAddr_ff == `OFF_BUFFER &&
             idleFree) begin
            buffer_ff <= wData_ff;
            txReq_ff  <= 1'b1;
         end
         if (wrEn && wLane_ff && awAddr_ff == `OFF_CTRL2) begin
            ctrl_ff <= wData_ff;
         end else if (collEv_ff || doneEv_ff) begin
            ctrl_ff[`BIT_RSTART] <= 1'b0;
            ctrl_ff[`BIT_STOP]   <= 1'b0;
         end
      end
   end

   // Sticky flags; a hardware set wins over a write-one-to-clear.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_ff     <= 2'b00;
         stopSeen_ff  <= 1'b0;
         startSeen_ff <= 1'b0;
         collPend_ff  <= 1'b0;
      end else begin
         if (wrEn && wLane_ff && awAddr_ff == `OFF_FLAGS) begin
            flags_ff <= flags_ff & ~wData_ff[1:0];
         end
         if (collEv_ff) begin
            flags_ff[`BIT_COLL] <= 1'b1;
            collPend_ff <= 1'b1;
         end
         if (doneEv_ff || txDone_ff) begin
            flags_ff[`BIT_IRQ] <= 1'b1;
         end
         if (stopBus) begin
            stopSeen_ff  <= 1'b1;
            startSeen_ff <= 1'b0;
            if (collPend_ff) begin
               flags_ff[`BIT_IRQ] <= 1'b1;
               collPend_ff <= 1'b0;
            end
         end else if (startBus) begin
            startSeen_ff <= 1'b1;
            stopSeen_ff  <= 1'b0;
         end
      end
   end

   // Baud generator: one decrement per two clocks gives a timed phase of
   // two times reload plus three clocks from the load request.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         brgCnt_ff <= 8'h00;
         brgPre_ff <= 1'b0;
         brgRun_ff <= 1'b0;
      end else if (brgLoad_ff) begin
         brgCnt_ff <= reload_ff;
         brgPre_ff <= 1'b0;
         brgRun_ff <= 1'b1;
      end else if (brgExp) begin
         brgRun_ff <= 1'b0;
         brgPre_ff <= 1'b0;
      end else if (brgRun_ff) begin
         brgPre_ff <= ~brgPre_ff;
         if (brgPre_ff) begin
            brgCnt_ff <= brgCnt_ff - 8'h01;
         end
      end
   end

   // Sequencer for repeated start, stop and byte transfers.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff   <= ST_IDLE;
         sdaOe      <= 1'b0;
         sclOe      <= 1'b0;
         brgLoad_ff <= 1'b0;
         collEv_ff  <= 1'b0;
         doneEv_ff  <= 1'b0;
         txDone_ff  <= 1'b0;
         txSh_ff    <= 9'h000;
         bitCnt_ff  <= 4'h0;
      end else begin
         brgLoad_ff <= 1'b0;
         collEv_ff  <= 1'b0;
         doneEv_ff  <= 1'b0;
         txDone_ff  <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (idleFree && ctrl_ff[`BIT_RSTART]) begin
                  sdaOe      <= 1'b0;
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_RS_REL;
               end else if (idleFree && ctrl_ff[`BIT_STOP]) begin
                  sdaOe    <= 1'b1;
                  state_ff <= ST_SP_SDAL;
               end else if (txReq_ff) begin
                  txSh_ff    <= {buffer_ff, 1'b1};
                  bitCnt_ff  <= 4'h0;
                  sclOe      <= 1'b1;
                  sdaOe      <= ~buffer_ff[7];
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_TX_LOW;
               end
            end
            ST_RS_REL: begin
               if (brgExp) begin
                  sclOe    <= 1'b0;
                  state_ff <= ST_RS_SCLH;
               end
            end
            ST_RS_SCLH: begin
               if (sync_ff.scl && !sync_ff.sda) begin
                  collEv_ff <= 1'b1;
                  sdaOe     <= 1'b0;
                  sclOe     <= 1'b0;
                  state_ff  <= ST_IDLE;
               end else if (sync_ff.scl) begin
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_RS_CHK;
               end
            end
            ST_RS_CHK: begin
               if (!sync_ff.scl) begin
                  collEv_ff <= 1'b1;
                  sdaOe     <= 1'b0;
                  sclOe     <= 1'b0;
                  state_ff  <= ST_IDLE;
               end else if (brgExp) begin
                  // An early SDA fall by another master is no collision.
                  sdaOe      <= 1'b1;
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_RS_SDAL;
               end
            end
            ST_RS_SDAL: begin
               if (brgExp) begin
                  sclOe     <= 1'b1;
                  doneEv_ff <= 1'b1;
                  state_ff  <= ST_IDLE;
               end
            end
            ST_SP_SDAL: begin
               if (!sync_ff.sda) begin
                  sclOe    <= 1'b0;
                  state_ff <= ST_SP_SCLH;
               end
            end
            ST_SP_SCLH: begin
               if (sync_ff.scl) begin
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_SP_CNT;
               end
            end
            ST_SP_CNT: begin
               if (!sync_ff.scl) begin
                  collEv_ff <= 1'b1;
                  sdaOe     <= 1'b0;
                  state_ff  <= ST_IDLE;
               end else if (brgExp) begin
                  sdaOe      <= 1'b0;
                  brgLoad_ff <= 1'b1;
                  state_ff   <= ST_SP_REL;
               end
            end
            ST_SP_REL: begin
               if (!sync_ff.scl && !sync_ff.sda) begin
                  collEv_ff <= 1'b1;
                  state_ff  <= ST_IDLE;
               end else if (brgExp && !sync_ff.sda) begin
                  collEv_ff <= 1'b1;
                  state_ff  <= ST_IDLE;
               end else if (brgExp) begin
                  doneEv_ff <= 1'b1;
                  state_ff  <= ST_IDLE;
               end
            end
            ST_TX_LOW: begin
               if (brgExp) begin
                  sclOe    <= 1'b0;
                  state_ff <= ST_TX_HIGH;
               end
            end
            ST_TX_HIGH: begin
               // Clock stretching: count only once SCL reads high.
               if (sync_ff.scl && !brgRun_ff && !brgLoad_ff) begin
                  brgLoad_ff <= 1'b1;
               end else if (brgExp) begin
                  sclOe <= 1'b1;
                  if (bitCnt_ff == `TX_LAST_BIT) begin
                     txDone_ff <= 1'b1;
                     state_ff  <= ST_IDLE;
                  end else begin
                     bitCnt_ff  <= bitCnt_ff + 4'h1;
                     txSh_ff    <= {txSh_ff[7:0], 1'b1};
                     sdaOe      <= ~txSh_ff[7];
                     brgLoad_ff <= 1'b1;
                     state_ff   <= ST_TX_LOW;
                  end
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Open-drain: the data level driven is always low.
   always_ff @(posedge clk) begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
   end
endmodule // i2c_master_collision_brg

/* inc/i2c_brg_consts.svh */
// Offsets, field positions, reset values and codes for the collision
// and baud generator block. Assumes a 32-bit AXI4-Lite register bus.
`ifndef I2C_BRG_CONSTS_SVH
`define I2C_BRG_CONSTS_SVH
`define OFF_RELOAD 8'h00
`define OFF_BUFFER 8'h04
`define OFF_CTRL2 8'h08
`define OFF_FLAGS 8'h0c
`define OFF_STATUS 8'h10
`define BIT_RSTART 1
`define BIT_STOP 2
`define BIT_IRQ 0
`define BIT_COLL 1
`define BIT_STOPSEEN 4
`define BIT_STARTSEEN 3
`define BIT_BUSY 2
`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define TX_LAST_BIT 4'h8
`endif

/* inc/i2c_brg_pkg.sv */
// Types shared by the collision and baud generator block.
// Assumes the constants header is compiled alongside.
package i2c_brg_pkg;
   typedef enum logic [10:0] {
      ST_IDLE    = 11'h001,
      ST_RS_REL  = 11'h002,
      ST_RS_SCLH = 11'h004,
      ST_RS_CHK  = 11'h008,
      ST_RS_SDAL = 11'h010,
      ST_SP_SDAL = 11'h020,
      ST_SP_SCLH = 11'h040,
      ST_SP_CNT  = 11'h080,
      ST_SP_REL  = 11'h100,
      ST_TX_LOW  = 11'h200,
      ST_TX_HIGH = 11'h400
   } state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } lines_t;
endpackage

/* verification/i2c_bus_partner.sv */
// Far side of the bus: pull-ups, other masters and a listening slave.
// Assumes the block's enables are high while it pulls a line low.
module i2c_bus_partner (
   input  wire logic       clk,
   input  wire logic       sdaOe,
   input  wire logic       sclOe,
   input  wire logic       holdSda,
   input  wire logic       holdScl,
   output logic            sda,
   output logic            scl,
   output logic [8:0]      rxBits,
   output int              sclPeriod
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sclPrev = 1'b1;
   int   sinceRise = 0;
   // A released line is lifted by its pull-up; any party may pull it.
   assign sda = !(sdaOe || holdSda);
   assign scl = !(sclOe || holdScl);
   // The slave shifts SDA in at each SCL rise and times the period.
   always @(posedge clk) begin
      sclPrev <= scl;
      sinceRise <= sinceRise + 1;
      if (scl && !sclPrev) begin
         rxBits <= {rxBits[7:0], sda};
         sclPeriod <= sinceRise;
         sinceRise <= 1;
      end
   end
endmodule // i2c_bus_partner

/* verification/i2c_master_collision_brg_chk.sv */
// Port assertions for the collision and baud generator block.
// Assumes a master that offers write address and data together.
`include "i2c_brg_consts.svh"
module i2c_master_collision_brg_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        sclIn,
   input wire logic        sdaOut,
   input wire logic        sdaOe,
   input wire logic        sclOut,
   input wire logic        sclOe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] reloadSeen;
   int         gap;
   always_ff @(posedge clk) begin
      if (!resetn)
         reloadSeen <= 8'h00;
      else if (awvalid && awready && wvalid && wready && wstrb[0] &&
               awaddr == `OFF_RELOAD)
         reloadSeen <= wdata[7:0];
   end
   // Cycles since the SCL enable last moved, saturating.
   always_ff @(posedge clk) begin
      if (!resetn)
         gap <= 1000;
      else if ($changed(sclOe))
         gap <= 1;
      else if (gap < 1000)
         gap <= gap + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence sWrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence sRdTaken;
      arvalid && arready;
   endsequence
   // The response leaves two cycles after both channels were taken.
   a_write_answer: assert property (sWrTaken |=> !awready ##1 bvalid)
      else $error("write not answered");
   a_read_answer: assert property (sRdTaken |=> rvalid && !arready)
      else $error("read not answered");
   a_unmapped_read: assert property (sRdTaken ##0 araddr > `OFF_STATUS
      |=> rresp == `RESP_SLVERR) else $error("unmapped read accepted");
   a_open_drain: assert property (!sdaOut && !sclOut)
      else $error("line driven high");
   a_scl_halfper: assert property ($changed(sclOe)
      |-> gap > reloadSeen) else $error("SCL phase shorter than reload");
   a_stop_sdarel: assert property ($fell(sdaOe) && !sclOe && sclIn
      |-> $past(sclIn, 4)) else $error("SDA released too soon");
   // A data bit that changes as SCL is pulled low is not a repeated start.
   a_rs_order: assert property ($rose(sclOe) && $stable(sdaOe)
      && sdaOe |-> $past(sdaOe, 3))
      else $error("SCL low too soon after SDA low");
   a_scl_afterdata: assert property ($fell(sclOe)
      |-> $stable(sdaOe) && sdaOe == $past(sdaOe, 2))
      else $error("SDA moved as SCL was released");
endmodule // i2c_master_collision_brg_chk
bind i2c_master_collision_brg i2c_master_collision_brg_chk chk (
   .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
   .wready, .bvalid, .araddr, .arvalid, .arready, .rresp, .rvalid, .sclIn,
   .sdaOut, .sdaOe, .sclOut, .sclOe
);

/* verification/i2c_master_collision_brg_tb.sv */
// Bench: register map, stop, repeated start, transmit and collisions.
// Assumes the partner model resolves both open-drain lines.
`include "i2c_brg_consts.svh"
module i2c_master_collision_brg_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  a;
      logic [3:0]  s;
      logic [31:0] d;
      logic [1:0]  br;
      logic [31:0] rv;
      logic [1:0]  rr;
   } row_t;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        holdSda = 1'b0;
   logic        holdScl = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, keep;
   logic        sdaOut, sdaOe, sclOut, sclOe, sda, scl;
   logic [1:0]  bresp, rresp, br, rr;
   logic [31:0] rdata, d;
   logic [8:0]  rxBits;
   int          sclPeriod, n;
   int          n_fail = 0;
   int          n_checks = 0;
   row_t        rows [7] = '{
      '{`OFF_RELOAD, 4'h0, 32'hff, `RESP_OKAY, 32'h0, `RESP_OKAY},
      '{`OFF_RELOAD, 4'h1, 32'h1ab, `RESP_OKAY, 32'hab, `RESP_OKAY},
      '{`OFF_BUFFER, 4'h0, 32'hff, `RESP_OKAY, 32'h0, `RESP_OKAY},
      '{`OFF_CTRL2, 4'h0, 32'h06, `RESP_OKAY, 32'h0, `RESP_OKAY},
      '{`OFF_FLAGS, 4'h1, 32'h03, `RESP_OKAY, 32'h0, `RESP_OKAY},
      '{`OFF_STATUS, 4'h0, 32'hff, `RESP_OKAY, 32'h0, `RESP_OKAY},
      '{8'h14, 4'h1, 32'hff, `RESP_SLVERR, 32'h0, `RESP_SLVERR}};
   i2c_master_collision_brg uut (
      .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .sdaIn(sda),
      .sdaOut, .sdaOe, .sclIn(scl), .sclOut, .sclOe);
   i2c_bus_partner far (
      .clk, .sdaOe, .sclOe, .holdSda, .holdScl, .sda, .scl, .rxBits,
      .sclPeriod);
   always #25 clk = ~clk;
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic hang;
      n_fail++;
      $display("CHECK FAILED wait expected done seen timeout");
      conclude;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic endTest(string t);
      $display("test %s done", t);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s,
                     output logic [1:0] resp);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 50) hang;
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 50) hang;
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] v);
      logic [1:0] r;
      wr(a, v, 4'h1, r);
   endtask
   task automatic cr(string what, logic [7:0] a, logic [31:0] exp);
      logic [31:0] v;
      logic [1:0]  r;
      rd(a, v, r);
      chk(what, exp, v);
   endtask
   // Counts cycles until the chosen enable shows the wanted level.
   task automatic wt(logic sel, logic lvl, output int cnt);
      for (cnt = 1; cnt < 500; cnt++) begin
         @(posedge clk);
         if ((sel ? sclOe : sdaOe) === lvl) break;
      end
      if (cnt == 500) hang;
   endtask
   task automatic waitIdle;
      int i;
      repeat (4) @(posedge clk);
      for (i = 0; i < 400; i++) begin
         rd(`OFF_STATUS, d, rr);
         if (d[`BIT_BUSY] === 1'b0) break;
      end
      if (i == 400) hang;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].s, br);
         rd(rows[i].a, d, rr);
         chk("bresp", rows[i].br, br);
         chk("rresp", rows[i].rr, rr);
         if (rows[i].rr === `RESP_OKAY)
            chk("rdata", rows[i].rv, d);
      end
      endTest("registers");
      wreg(`OFF_RELOAD, 32'h10);
      wreg(`OFF_CTRL2, 32'h04);
      wt(1'b0, 1'b1, n);
      wt(1'b0, 1'b0, n);
      chk("stop count", 1, n >= 32 && n <= 48);
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h1);
      rd(`OFF_STATUS, d, rr);
      chk("stop seen", 1, d[`BIT_STOPSEEN]);
      wreg(`OFF_FLAGS, 32'h3);
      endTest("stop");
      wreg(`OFF_CTRL2, 32'h02);
      wt(1'b0, 1'b1, n);
      chk("scl at sda low", 0, sclOe);
      wt(1'b1, 1'b1, n);
      chk("sda to scl", 1, n >= 32 && n <= 48);
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h1);
      cr("ctrl2", `OFF_CTRL2, 32'h0);
      wreg(`OFF_FLAGS, 32'h3);
      wreg(`OFF_CTRL2, 32'h02);
      wt(1'b1, 1'b0, n);
      repeat (8) @(posedge clk);
      holdSda <= 1'b1;
      waitIdle;
      holdSda <= 1'b0;
      cr("flags", `OFF_FLAGS, 32'h1);
      wreg(`OFF_FLAGS, 32'h3);
      endTest("repeated start");
      wreg(`OFF_BUFFER, 32'ha5);
      waitIdle;
      chk("byte", 9'h14b, rxBits);
      chk("period", 1, sclPeriod >= 68 && sclPeriod <= 80);
      keep = sclOe;
      repeat (100) @(posedge clk);
      chk("scl held", keep, sclOe);
      chk("no clocks", 9'h14b, rxBits);
      wreg(`OFF_FLAGS, 32'h3);
      endTest("transmit");
      wreg(`OFF_CTRL2, 32'h04);
      wt(1'b0, 1'b1, n);
      holdSda <= 1'b1;
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h2);
      cr("ctrl2", `OFF_CTRL2, 32'h0);
      chk("lines", 2'b00, {sdaOe, sclOe});
      holdSda <= 1'b0;
      repeat (8) @(posedge clk);
      cr("flags", `OFF_FLAGS, 32'h3);
      wreg(`OFF_FLAGS, 32'h3);
      wreg(`OFF_CTRL2, 32'h04);
      wt(1'b0, 1'b1, n);
      repeat (10) @(posedge clk);
      holdScl <= 1'b1;
      repeat (10) @(posedge clk);
      holdScl <= 1'b0;
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h2);
      chk("lines", 2'b00, {sdaOe, sclOe});
      wreg(`OFF_FLAGS, 32'h3);
      endTest("stop collisions");
      holdSda <= 1'b1;
      wreg(`OFF_CTRL2, 32'h02);
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h2);
      chk("lines", 2'b00, {sdaOe, sclOe});
      holdSda <= 1'b0;
      repeat (8) @(posedge clk);
      wreg(`OFF_FLAGS, 32'h3);
      holdScl <= 1'b1;
      wreg(`OFF_CTRL2, 32'h02);
      repeat (60) @(posedge clk);
      chk("sda while stretched", 0, sdaOe);
      holdScl <= 1'b0;
      repeat (12) @(posedge clk);
      holdScl <= 1'b1;
      repeat (6) @(posedge clk);
      holdScl <= 1'b0;
      waitIdle;
      cr("flags", `OFF_FLAGS, 32'h2);
      chk("sda not driven", 0, sdaOe);
      endTest("repeated start collisions");
      // A reset in mid-run must drop the flags and the reload value.
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("reset ready", 32'h7, {awready, wready, arready});
      chk("reset idle", 32'h0, {sdaOe, sclOe, bvalid, rvalid});
      cr("reset reload", `OFF_RELOAD, 32'h0);
      cr("reset flags", `OFF_FLAGS, 32'h0);
      endTest("reset");
      conclude;
   end
endmodule // i2c_master_collision_brg_tb
